// ==== src/mpf_pkg.sv ====
// Constants, register map and field layout of the pause flow control block.
// Assumes a 250 MHz APB clock and a byte-wide receive stream from the MAC.
package mpf_pkg;

  // ------------------------------------------------------------------
  // Register map (index, byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [9:0] MPF_FLOW_IDX = 10'h008;
  localparam logic [9:0] MPF_MODE_IDX = 10'h010;
  localparam logic [31:0] MPF_FLOW_RESET = 32'h0000_0000;
  localparam logic [31:0] MPF_MODE_RESET = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int MPF_PT_LSB = 16;
  localparam int MPF_PT_MSB = 31;
  localparam int MPF_PASS_BIT = 2;
  localparam int MPF_FLOW_CONTROL_ENABLE_BIT = 1;
  localparam int MPF_BUSY_BIT = 0;
  localparam int MPF_FDX_BIT = 0;
  localparam int MPF_TXEN_BIT = 1;
  localparam int MPF_PROM_BIT = 2;
  localparam int MPF_SPD_BIT = 3;
  localparam int MPF_HOLD_BIT = 4;
  localparam logic [31:0] MPF_MODE_WMASK = 32'h0000_000f;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int MPF_CLK_PS = 4000;
  localparam int MPF_SLOT_BITS = 512;
  localparam int MPF_BIT_PS_100 = 10000;
  localparam int MPF_BIT_PS_10 = 100000;
  localparam int MPF_SLOT_CYC_100 =
    (MPF_SLOT_BITS * MPF_BIT_PS_100 + MPF_CLK_PS - 1) / MPF_CLK_PS;
  localparam int MPF_SLOT_CYC_10 =
    (MPF_SLOT_BITS * MPF_BIT_PS_10 + MPF_CLK_PS - 1) / MPF_CLK_PS;

  // ------------------------------------------------------------------
  // PAUSE frame layout
  // ------------------------------------------------------------------
  localparam logic [4:0] MPF_SA_FIRST = 5'd6;
  localparam logic [4:0] MPF_SA_LAST = 5'd11;
  localparam logic [4:0] MPF_PT_HI_POS = 5'd16;
  localparam logic [4:0] MPF_PT_LO_POS = 5'd17;
  localparam logic [4:0] MPF_MIN_LEN = 5'd18;

  // Expected header byte at a position of a PAUSE frame
  function automatic logic [7:0] mpf_hdr_byte(input logic [4:0] pos);
    case (pos)
      5'd0: mpf_hdr_byte = 8'h01;
      5'd1: mpf_hdr_byte = 8'h80;
      5'd2: mpf_hdr_byte = 8'hc2;
      5'd3: mpf_hdr_byte = 8'h00;
      5'd4: mpf_hdr_byte = 8'h00;
      5'd5: mpf_hdr_byte = 8'h01;
      5'd12: mpf_hdr_byte = 8'h88;
      5'd13: mpf_hdr_byte = 8'h08;
      5'd14: mpf_hdr_byte = 8'h00;
      5'd15: mpf_hdr_byte = 8'h01;
      default: mpf_hdr_byte = 8'h00;
    endcase
  endfunction

  // Byte address of a register index
  function automatic logic [11:0] mpf_addr(input logic [9:0] idx);
    mpf_addr = {idx, 2'b00};
  endfunction

endpackage

// ==== src/mpf_rx_if.sv ====
// Receive stream and decode result between the block and its PAUSE decoder.
// Assumes one byte per beat, first byte flagged by sof and last by eof.
interface mpf_rx_if;
  logic valid;
  logic [7:0] data;
  logic sof;
  logic eof;
  logic good;
  logic decode_en;
  logic done;
  logic is_pause;
  logic [15:0] time_val;

  modport src (output valid, data, sof, eof, good, decode_en, input done, is_pause, time_val);
  modport dec (input valid, data, sof, eof, good, decode_en, output done, is_pause, time_val);
endinterface

// ==== src/mpf_pause_decoder.sv ====
// Recognises valid PAUSE frames in the receive byte stream.
// Assumes bytes arrive without gaps counted, CRC already checked by the MAC.
module mpf_pause_decoder
  import mpf_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Stream and result
  mpf_rx_if.dec rx
);

  logic [4:0] pos_q;
  logic match_q;
  logic [15:0] time_q;
  logic done_q;
  logic pause_q;
  logic [4:0] pos_now;
  logic match_now;
  logic [15:0] time_now;

  assign pos_now = rx.sof ? 5'd0 : pos_q;

  always_comb begin
    match_now = rx.sof ? 1'b1 : match_q;
    time_now = time_q;
    if (pos_now == MPF_PT_HI_POS) begin
      time_now = {rx.data, time_q[7:0]};
    end else if (pos_now == MPF_PT_LO_POS) begin
      time_now = {time_q[15:8], rx.data};
    end else if (pos_now < MPF_SA_FIRST || pos_now > MPF_SA_LAST) begin
      if (pos_now < MPF_PT_HI_POS && rx.data != mpf_hdr_byte(pos_now)) begin
        match_now = 1'b0;
      end
    end
  end

  // Byte position and running header match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q <= 5'd0;
      match_q <= 1'b0;
      time_q <= 16'h0000;
    end else if (ce && rx.valid) begin
      pos_q <= (pos_now == MPF_MIN_LEN) ? pos_now : pos_now + 5'd1;
      match_q <= match_now;
      time_q <= time_now;
    end
  end

  // Result at end of frame; is_pause stays low while decoding is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      pause_q <= 1'b0;
    end else if (ce) begin
      done_q <= rx.valid && rx.eof;
      pause_q <= rx.valid && rx.eof && rx.good && rx.decode_en && match_now
        && (pos_now + 5'd1 >= MPF_MIN_LEN);
    end
  end

  assign rx.done = done_q;
  assign rx.is_pause = pause_q;
  assign rx.time_val = time_q;

endmodule

// ==== src/mpf_flow_ctrl.sv ====
// Pause flow control: register, PAUSE reception, transmit hold, PAUSE send, back pressure.
// Assumes an APB master on the register side and the MAC datapath on the link side.
module mpf_flow_ctrl
  import mpf_pkg::*;
#(
  parameter int unsigned SLOT_CYC_100 = MPF_SLOT_CYC_100,
  parameter int unsigned SLOT_CYC_10 = MPF_SLOT_CYC_10
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive stream from MAC
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic rx_good,
  input wire logic rx_addr_pass,
  // Receive stream to application
  output logic rx_out_valid,
  output logic [7:0] rx_out_data,
  output logic rx_out_last,
  output logic rx_status_valid,
  output logic rx_status_filter,
  output logic rx_status_pause,
  // Receive buffer congestion
  input wire logic rx_congested,
  // Transmitter side
  output logic tx_hold,
  output logic pause_tx_req,
  output logic [15:0] pause_tx_time,
  input wire logic pause_tx_done,
  output logic backpressure
);

  // ------------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------------
  logic [15:0] pause_time_value_q;
  logic pass_control_frames_q;
  logic flow_control_enable_q;
  logic [3:0] mode_q;
  logic [31:0] prdata_q;
  logic slverr_q;
  logic flow_control_busy;
  logic full_duplex;
  logic tx_enable;
  logic promiscuous;
  logic speed_100;
  logic sel_flow;
  logic sel_mode;
  logic wr_en;

  assign full_duplex = mode_q[MPF_FDX_BIT];
  assign tx_enable = mode_q[MPF_TXEN_BIT];
  assign promiscuous = mode_q[MPF_PROM_BIT];
  assign speed_100 = mode_q[MPF_SPD_BIT];

  // ------------------------------------------------------------------
  // Operating modes
  // ------------------------------------------------------------------
  logic pause_mode;
  logic bp_mode;

  // PAUSE handling needs full duplex; back pressure is its half-duplex twin
  assign pause_mode = flow_control_enable_q && full_duplex;
  assign bp_mode = flow_control_enable_q && !full_duplex;

  // Address decode of the two mapped words
  always_comb begin
    sel_flow = 1'b0;
    sel_mode = 1'b0;
    if (paddr == mpf_addr(MPF_FLOW_IDX)) begin
      sel_flow = 1'b1;
    end else if (paddr == mpf_addr(MPF_MODE_IDX)) begin
      sel_mode = 1'b1;
    end
  end

  // Writes land at the access edge; no wait states are inserted
  assign wr_en = ce && psel && penable && pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = slverr_q;

  // Writes; the busy bit position is read-only and ignores written data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_time_value_q <= MPF_FLOW_RESET[MPF_PT_MSB:MPF_PT_LSB];
      pass_control_frames_q <= MPF_FLOW_RESET[MPF_PASS_BIT];
      flow_control_enable_q <= MPF_FLOW_RESET[MPF_FLOW_CONTROL_ENABLE_BIT];
      mode_q <= MPF_MODE_RESET[3:0];
    end else if (wr_en) begin
      if (sel_flow) begin
        pause_time_value_q <= pwdata[MPF_PT_MSB:MPF_PT_LSB];
        pass_control_frames_q <= pwdata[MPF_PASS_BIT];
        flow_control_enable_q <= pwdata[MPF_FLOW_CONTROL_ENABLE_BIT];
      end else if (sel_mode) begin
        mode_q <= pwdata[3:0] & MPF_MODE_WMASK[3:0];
      end
    end
  end

  // Read data prepared in the setup phase, valid throughout the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (ce && psel && !penable) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
      if (sel_flow) begin
        prdata_q[MPF_PT_MSB:MPF_PT_LSB] <= pause_time_value_q;
        prdata_q[MPF_PASS_BIT] <= pass_control_frames_q;
        prdata_q[MPF_FLOW_CONTROL_ENABLE_BIT] <= flow_control_enable_q;
        prdata_q[MPF_BUSY_BIT] <= flow_control_busy;
      end else if (sel_mode) begin
        prdata_q[3:0] <= mode_q;
        prdata_q[MPF_HOLD_BIT] <= tx_hold;
      end else begin
        slverr_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Receive path
  // ------------------------------------------------------------------
  mpf_rx_if rxi ();

  assign rxi.valid = rx_valid;
  assign rxi.data = rx_data;
  assign rxi.sof = rx_sof;
  assign rxi.eof = rx_eof;
  assign rxi.good = rx_good;
  assign rxi.decode_en = pause_mode;

  mpf_pause_decoder u_dec (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .rx(rxi.dec)
  );

  // ------------------------------------------------------------------
  // Forwarding and status
  // ------------------------------------------------------------------
  logic out_valid_q;
  logic [7:0] out_data_q;
  logic out_last_q;
  logic addr_pass_q;
  logic stat_valid_q;
  logic stat_filter_q;
  logic stat_pause_q;

  // Every byte is forwarded, whatever the frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid_q <= 1'b0;
      out_data_q <= 8'h00;
      out_last_q <= 1'b0;
      addr_pass_q <= 1'b0;
    end else if (ce) begin
      out_valid_q <= rx_valid;
      out_data_q <= rx_data;
      out_last_q <= rx_valid && rx_eof;
      if (rx_valid && rx_eof) begin
        addr_pass_q <= rx_addr_pass;
      end
    end
  end

  // Status word two cycles after the last byte is received, one cycle after rx_out_last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_valid_q <= 1'b0;
      stat_filter_q <= 1'b0;
      stat_pause_q <= 1'b0;
    end else if (ce) begin
      stat_valid_q <= rxi.done;
      stat_pause_q <= rxi.done && rxi.is_pause;
      if (promiscuous) begin
        stat_filter_q <= rxi.done;
      end else if (rxi.is_pause) begin
        stat_filter_q <= rxi.done && pass_control_frames_q;
      end else begin
        stat_filter_q <= rxi.done && addr_pass_q;
      end
    end
  end

  assign rx_out_valid = out_valid_q;
  assign rx_out_data = out_data_q;
  assign rx_out_last = out_last_q;
  assign rx_status_valid = stat_valid_q;
  assign rx_status_filter = stat_filter_q;
  assign rx_status_pause = stat_pause_q;

  // ------------------------------------------------------------------
  // Transmit hold timer
  // ------------------------------------------------------------------
  logic [15:0] quanta_q;
  logic [31:0] slot_cnt_q;
  logic [31:0] slot_last;
  logic pause_act;

  // One quantum of hold is one slot time at the current link speed
  assign slot_last = speed_100 ? SLOT_CYC_100 - 32'd1 : SLOT_CYC_10 - 32'd1;
  assign pause_act = rxi.is_pause && pause_mode;

  // A new PAUSE restarts the count; leaving full-duplex flow control drops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quanta_q <= 16'h0000;
      slot_cnt_q <= 32'd0;
    end else if (ce) begin
      if (!pause_mode) begin
        quanta_q <= 16'h0000;
      end else if (pause_act) begin
        quanta_q <= rxi.time_val;
        slot_cnt_q <= slot_last;
      end else if (quanta_q != 16'h0000) begin
        if (slot_cnt_q == 32'd0) begin
          quanta_q <= quanta_q - 16'h0001;
          slot_cnt_q <= slot_last;
        end else begin
          slot_cnt_q <= slot_cnt_q - 32'd1;
        end
      end
    end
  end

  // Hold stands while quanta remain; a PAUSE carrying zero time ends it
  assign tx_hold = (quanta_q != 16'h0000);

  // ------------------------------------------------------------------
  // PAUSE send and back pressure
  // ------------------------------------------------------------------
  // One PAUSE per congestion episode; a new one waits until congestion clears
  typedef enum logic [1:0] {MPF_IDLE, MPF_SEND, MPF_WAIT_CLR} mpf_tx_state_e;
  mpf_tx_state_e st_q;
  logic req_q;
  logic [15:0] req_time_q;
  logic bp_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= MPF_IDLE;
      req_q <= 1'b0;
      req_time_q <= 16'h0000;
    end else if (ce) begin
      case (st_q)
        MPF_IDLE: begin
          if (rx_congested && pause_mode && tx_enable) begin
            st_q <= MPF_SEND;
            req_q <= 1'b1;
            req_time_q <= pause_time_value_q;
          end
        end
        MPF_SEND: begin
          if (pause_tx_done) begin
            st_q <= MPF_WAIT_CLR;
            req_q <= 1'b0;
          end else if (!tx_enable) begin
            st_q <= MPF_WAIT_CLR;
            req_q <= 1'b0;
          end
        end
        default: begin
          if (!rx_congested) begin
            st_q <= MPF_IDLE;
          end
        end
      endcase
    end
  end

  // Back pressure follows congestion one cycle late and stops with the transmitter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bp_q <= 1'b0;
    end else if (ce) begin
      bp_q <= rx_congested && bp_mode && tx_enable;
    end
  end

  assign pause_tx_req = req_q;
  assign pause_tx_time = req_time_q;
  assign backpressure = bp_q;
  assign flow_control_busy = req_q || bp_q;

endmodule

// ==== tb/mpf_flow_ctrl_properties.sv ====
// Concurrent checks of the pause flow control block, bound to its top.
// Assumes one clock domain and registers written only over APB.
module mpf_flow_ctrl_properties
  import mpf_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Receive side
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_eof,
  input wire logic rx_congested,
  input wire logic rx_out_valid,
  input wire logic [7:0] rx_out_data,
  input wire logic rx_status_valid,
  input wire logic rx_status_filter,
  input wire logic rx_status_pause,
  // Transmitter side
  input wire logic tx_hold,
  input wire logic pause_tx_req,
  input wire logic [15:0] pause_tx_time,
  input wire logic pause_tx_done,
  input wire logic backpressure
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] flow_q;
  logic [3:0] mode_q;
  wire wr = psel && penable && pwrite && ce;
  wire fc_on = flow_q[1] && mode_q[0];
  wire hd_on = flow_q[1] && !mode_q[0] && mode_q[1];
  // --------------------------------------------------------------
  // Shadow copies of the written registers
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flow_q <= 32'h0;
    else if (wr && paddr == {MPF_FLOW_IDX, 2'b00}) flow_q <= pwdata;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_q <= 4'h0;
    else if (wr && paddr == {MPF_MODE_IDX, 2'b00}) mode_q <= pwdata[3:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  AST_PT: assert property ($rose(pause_tx_req) |-> pause_tx_time == flow_q[31:16])
    else $error("pause time differs from register");
  AST_FWD: assert property (rx_valid && ce |=> rx_out_valid && rx_out_data == $past(rx_data))
    else $error("received byte not forwarded");
  AST_STAT: assert property (rx_valid && rx_eof && ce |-> ##2 rx_status_valid)
    else $error("status word missing");
  AST_PROM: assert property (rx_status_valid && mode_q[2] |-> rx_status_filter)
    else $error("promiscuous did not set filter bit");
  AST_PASS: assert property (rx_status_valid && rx_status_pause && !mode_q[2]
    |-> rx_status_filter == flow_q[2]) else $error("filter bit differs from pass flag");
  AST_NODEC: assert property (rx_status_valid && !fc_on |-> !rx_status_pause)
    else $error("frame decoded with flow control off");
  AST_HOLD: assert property ((!fc_on) [*2] |-> !tx_hold)
    else $error("transmitter held outside full duplex flow control");
  AST_TXEN: assert property ((!mode_q[1]) [*2] |-> !pause_tx_req && !backpressure)
    else $error("flow control sent with transmitter off");
  AST_BP: assert property (rx_congested && hd_on |=> backpressure)
    else $error("back pressure missing");
  AST_ROSE: assert property ($rose(tx_hold) |-> rx_status_valid && rx_status_pause)
    else $error("hold started without a pause frame");
  AST_DONE: assert property (pause_tx_req && pause_tx_done |=> !pause_tx_req)
    else $error("request stands after frame sent");
  cover property (pause_tx_req && pause_tx_done);
  cover property ($rose(tx_hold));
  cover property (backpressure);
endmodule

bind mpf_flow_ctrl mpf_flow_ctrl_properties i_mpf_flow_ctrl_properties (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rx_valid(rx_valid),
  .rx_data(rx_data), .rx_eof(rx_eof), .rx_congested(rx_congested),
  .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data),
  .rx_status_valid(rx_status_valid), .rx_status_filter(rx_status_filter),
  .rx_status_pause(rx_status_pause), .tx_hold(tx_hold), .pause_tx_req(pause_tx_req),
  .pause_tx_time(pause_tx_time), .pause_tx_done(pause_tx_done),
  .backpressure(backpressure));

// ==== tb/mpf_tx_model.sv ====
// Transmitter that sends the requested PAUSE frame after dly cycles.
// Assumes the request stands until the done pulse is seen.
module mpf_tx_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request from the block
  input wire logic pause_tx_req,
  input wire logic [15:0] pause_tx_time,
  input wire logic [7:0] dly,
  // Completion and record
  output logic pause_tx_done,
  output logic [15:0] sent_time,
  output logic [7:0] n_sent
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h0;
      pause_tx_done <= 1'b0;
      sent_time <= 16'h0;
      n_sent <= 8'h0;
    end else if (pause_tx_done) begin
      pause_tx_done <= 1'b0;
      cnt_q <= 8'h0;
    end else if (pause_tx_req && cnt_q == dly) begin
      pause_tx_done <= 1'b1;
      sent_time <= pause_tx_time;
      n_sent <= n_sent + 8'h1;
    end else if (pause_tx_req) begin
      cnt_q <= cnt_q + 8'h1;
    end
  end
endmodule

// ==== tb/mpf_flow_ctrl_test.sv ====
// Self-checking bench of the pause flow control block.
// Assumes the transmitter model beside it and the bound checker.
module mpf_flow_ctrl_test
  import mpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_FLOW = {MPF_FLOW_IDX, 2'b00};
  localparam logic [11:0] A_MODE = {MPF_MODE_IDX, 2'b00};
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, rx_addr_pass = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic rx_valid = 1'b0, rx_sof = 1'b0, rx_eof = 1'b0, rx_good = 1'b0, rx_congested = 1'b0;
  logic [7:0] rx_data = 8'h0, dly = 8'h14, n_sent, rx_out_data;
  logic rx_out_valid, rx_out_last, rx_status_valid, rx_status_filter, rx_status_pause;
  logic tx_hold, pause_tx_req, pause_tx_done, backpressure;
  logic [15:0] pause_tx_time, sent_time;
  logic [7:0] hdr [0:15] = '{8'h01, 8'h80, 8'hc2, 8'h00, 8'h00, 8'h01, 8'h5a, 8'h5a,
    8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'h88, 8'h08, 8'h00, 8'h01};
  int n_errors = 0, checks = 0;

  mpf_flow_ctrl #(.SLOT_CYC_100(2), .SLOT_CYC_10(4)) i_mpf_flow_ctrl (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof),
    .rx_eof(rx_eof), .rx_good(rx_good), .rx_addr_pass(rx_addr_pass),
    .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data), .rx_out_last(rx_out_last),
    .rx_status_valid(rx_status_valid), .rx_status_filter(rx_status_filter),
    .rx_status_pause(rx_status_pause), .rx_congested(rx_congested), .tx_hold(tx_hold),
    .pause_tx_req(pause_tx_req), .pause_tx_time(pause_tx_time),
    .pause_tx_done(pause_tx_done), .backpressure(backpressure));
  mpf_tx_model i_mpf_tx_model (.pclk(pclk), .presetn(presetn), .pause_tx_req(pause_tx_req),
    .pause_tx_time(pause_tx_time), .dly(dly), .pause_tx_done(pause_tx_done),
    .sent_time(sent_time), .n_sent(n_sent));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic tmo;
    n_errors++;
    test_done();
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 16) tmo();
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic wfor(ref logic s, input logic v);
    int k;
    for (k = 0; k < 200; k++) begin
      @(negedge pclk);
      if (s === v) break;
    end
    if (k == 200) tmo();
  endtask
  // Sends a PAUSE frame, checks its status and how long transmit is held
  task automatic frame(input logic [15:0] tm, input logic g, input logic ep,
    input logic ef, input int h);
    int i, n;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_eof <= (i == 19);
      rx_good <= g;
      rx_data <= (i < 16) ? hdr[i] : (i == 16) ? tm[15:8] : (i == 17) ? tm[7:0] : 8'h0;
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_eof <= 1'b0;
    @(negedge pclk);
    chk("out_last", 1, rx_out_last);
    wfor(rx_status_valid, 1'b1);
    chk("status_pause", ep, rx_status_pause);
    chk("status_filter", ef, rx_status_filter);
    n = 0;
    while (tx_hold === 1'b1 && n < 500) begin
      n++;
      @(negedge pclk);
    end
    chk("hold_cycles", 1, (h == 0) ? (n == 0) : (n + 1 >= h && n <= h + 1));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rdc("flow_reset", A_FLOW, 32'h0);
    rdc("mode_reset", A_MODE, 32'h0);
    apb(1'b1, 12'h100, 32'hffff_ffff);
    chk("unmapped_err", 1, er);
    rdc("unmapped_rd", 12'h100, 32'h0);
    apb(1'b1, A_FLOW, 32'h0003_0000);
    rdc("flow_idle", A_FLOW, 32'h0003_0000);
    apb(1'b1, A_FLOW, 32'h0003_0006);
    rdc("flow_rw", A_FLOW, 32'h0003_0006);
    @(posedge pclk);
    ce <= 1'b0;
    apb(1'b1, A_FLOW, 32'h0001_0000);
    ce <= 1'b1;
    rdc("ce_frozen", A_FLOW, 32'h0003_0006);
  endtask
  task automatic t_rx;
    apb(1'b1, A_MODE, 32'h0000_000b);
    frame(16'h0002, 1'b1, 1'b1, 1'b1, 4);
    @(posedge pclk);
    rx_addr_pass <= 1'b0;
    frame(16'h0002, 1'b0, 1'b0, 1'b0, 0);
    apb(1'b1, A_MODE, 32'h0000_0003);
    rx_addr_pass <= 1'b1;
    frame(16'h0002, 1'b1, 1'b1, 1'b1, 8);
    apb(1'b1, A_FLOW, 32'h0003_0002);
    frame(16'h0001, 1'b1, 1'b1, 1'b0, 4);
    apb(1'b1, A_MODE, 32'h0000_0007);
    frame(16'h0001, 1'b1, 1'b1, 1'b1, 4);
    apb(1'b1, A_FLOW, 32'h0003_0000);
    frame(16'h0002, 1'b1, 1'b0, 1'b1, 0);
    apb(1'b1, A_MODE, 32'h0000_000a);
    apb(1'b1, A_FLOW, 32'h0003_0002);
    frame(16'h0002, 1'b1, 1'b0, 1'b1, 0);
  endtask
  task automatic t_tx;
    int e;
    apb(1'b1, A_MODE, 32'h0000_000b);
    apb(1'b1, A_FLOW, 32'h0005_0002);
    for (e = 0; e < 2; e++) begin
      @(posedge pclk);
      dly <= (e == 0) ? 8'h14 : 8'h0;
      rx_congested <= 1'b1;
      wfor(pause_tx_req, 1'b1);
      chk("tx_time", 32'h5, pause_tx_time);
      if (e == 0) rdc("busy_set", A_FLOW, 32'h0005_0003);
      wfor(pause_tx_req, 1'b0);
      rdc("busy_clr", A_FLOW, 32'h0005_0002);
      chk("sent", e + 1, n_sent);
      chk("sent_time", 32'h5, sent_time);
      @(posedge pclk);
      rx_congested <= 1'b0;
    end
  endtask
  task automatic t_bp;
    apb(1'b1, A_MODE, 32'h0000_0002);
    @(posedge pclk);
    rx_congested <= 1'b1;
    wfor(backpressure, 1'b1);
    rdc("bp_busy", A_FLOW, 32'h0005_0003);
    chk("bp_no_pause", 0, pause_tx_req);
    apb(1'b1, A_MODE, 32'h0000_0000);
    repeat (3) @(negedge pclk);
    chk("bp_txoff", 0, backpressure);
    @(posedge pclk);
    rx_congested <= 1'b0;
    apb(1'b1, A_MODE, 32'h0000_0001);
    rx_congested <= 1'b1;
    repeat (8) @(negedge pclk);
    chk("req_txoff", 0, pause_tx_req);
    chk("sent_txoff", 2, n_sent);
    @(posedge pclk);
    rx_congested <= 1'b0;
  endtask

  initial begin
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (50000) @(posedge pclk);
    tmo();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rx();
    t_tx();
    t_bp();
    test_done();
  end
endmodule
